// >>> acs_sequencer.v
// Overview of operation
// - adjusting command selected only by codes 3EH then 00H in bytes 1 and 2
// - byte 5 sub-command, bytes 6-7 address, bytes 8-9 data, both directions
// - sub-command 01H writes setting data to setting address
// - 1007H to 2000H selects autotuning results write mode
// - 1008H to 2000H selects absolute encoder setup mode
// - 1013H to 2000H selects multi-turn limit setting mode
// - 01H to 2001H executes the selected adjustment mode
// - encoder and multi-turn modes accept save 02H to 2001H before execute
// - accepted step sets ready flag and echoes address and data
// - execute step waits one second before ready flag rises
// - autotuned inertia is volatile, restarts from factory or saved values
// - saved results become initial values next power-on, may change ratio
// - inertia ratio 0 to 20000 percent, default 0, effective after restart
// - inertia ratio is load over rotor inertia times 100, used by autotuning
// - method 0 estimates inertia only during first run after power-on; code stops at the first estimate taken, in whichever run
// - method 1 calculates inertia continuously
// - method 2 disables normal autotuning
// - method digit defaults to 0
// - correct answer equals sub-command, address unchanged, alarm and warning 0
//
// top of the adjusting command interpreter; command fields arrive as a one-cycle frame strobe
// assumes i_restart stands for the power cycle that activates stored settings
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_sequencer #(
  parameter EXEC_CYCLES = `ACS_EXEC_CYCLES,
  parameter TIMER_W = 28
)
(
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_restart,
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_byte1,
  input wire [7:0] i_cmd_byte2,
  input wire [7:0] i_sub_command_code,
  input wire [15:0] i_setting_address,
  input wire [15:0] i_setting_value,
  input wire i_ratio_wr,
  input wire [15:0] i_ratio_wdata,
  input wire i_method_wr,
  input wire [3:0] i_method_wdata,
  input wire i_running,
  input wire i_est_valid,
  input wire [15:0] i_est_ratio,
  output reg o_rsp_valid,
  output reg [7:0] o_sub_command_answer,
  output reg [15:0] o_setting_address,
  output reg [15:0] o_setting_value,
  output reg o_command_ready_flag,
  output reg o_warning,
  output wire o_alarm,
  output reg [1:0] o_mode,
  output reg o_saved,
  output reg o_tune_save_pulse,
  output reg o_enc_setup_pulse,
  output reg o_mt_limit_pulse,
  output wire [15:0] o_inertia_ratio_setting,
  output wire [15:0] o_active_inertia,
  output wire o_estimating,
  output reg [3:0] o_autotuning_method_setting,
  output wire o_ratio_rejected
);
  localparam ST_IDLE = 1'b0;
  localparam ST_EXEC = 1'b1;

  reg state_reg;
  reg [3:0] method_pending_reg;
  reg [1:0] exec_mode_reg;
  reg timer_start;
  reg tune_save_req;
  wire timer_busy;
  wire timer_done;
  wire is_adj;
  wire is_write;
  wire mode_wr;
  wire step_wr;
  wire is_exec;
  wire is_save;

  assign is_adj = i_cmd_valid && (i_cmd_byte1 == `ACS_CMD_ADJ) &&
                  (i_cmd_byte2 == `ACS_CMD_SUB);
  assign is_write = is_adj && (i_sub_command_code == `ACS_SUB_WRITE);
  assign mode_wr = is_write && (i_setting_address == `ACS_ADDR_MODE);
  assign step_wr = is_write && (i_setting_address == `ACS_ADDR_STEP);
  assign is_exec = step_wr && (i_setting_value == `ACS_STEP_EXECUTE);
  assign is_save = step_wr && (i_setting_value == `ACS_STEP_SAVE);
  // no fault source inside this block; alarm is held low
  assign o_alarm = 1'b0;

  acs_exec_timer #(
    .CYCLES(EXEC_CYCLES),
    .W(TIMER_W)
  ) u_timer (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_start(timer_start),
    .o_busy(timer_busy),
    .o_done(timer_done)
  );

  acs_inertia_store u_store (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_restart(i_restart),
    .i_ratio_wr(i_ratio_wr),
    .i_ratio_wdata(i_ratio_wdata),
    .i_method(o_autotuning_method_setting),
    .i_running(i_running),
    .i_est_valid(i_est_valid),
    .i_est_ratio(i_est_ratio),
    .i_save(tune_save_req),
    .o_ratio_setting(o_inertia_ratio_setting),
    .o_active_ratio(o_active_inertia),
    .o_estimating(o_estimating),
    .o_ratio_rejected(o_ratio_rejected)
  );

  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= ST_IDLE;
      o_mode <= `ACS_SEL_NONE;
      exec_mode_reg <= `ACS_SEL_NONE;
      o_saved <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_sub_command_answer <= 8'h00;
      o_setting_address <= 16'h0000;
      o_setting_value <= 16'h0000;
      o_command_ready_flag <= 1'b1;
      o_warning <= 1'b0;
      timer_start <= 1'b0;
      tune_save_req <= 1'b0;
      o_tune_save_pulse <= 1'b0;
      o_enc_setup_pulse <= 1'b0;
      o_mt_limit_pulse <= 1'b0;
      method_pending_reg <= `ACS_METHOD_RESET;
      o_autotuning_method_setting <= `ACS_METHOD_RESET;
    end
    else if (i_ce)
    begin
      o_rsp_valid <= 1'b0;
      timer_start <= 1'b0;
      tune_save_req <= 1'b0;
      o_tune_save_pulse <= 1'b0;
      o_enc_setup_pulse <= 1'b0;
      o_mt_limit_pulse <= 1'b0;
      if (i_method_wr)
        method_pending_reg <= i_method_wdata;
      if (i_restart)
        o_autotuning_method_setting <= method_pending_reg;
      case (state_reg)
        ST_IDLE:
        begin
          if (is_adj)
          begin
            // every adjusting frame is echoed, even ones it cannot act on
            o_sub_command_answer <= i_sub_command_code;
            o_setting_address <= i_setting_address;
            o_setting_value <= i_setting_value;
            o_warning <= 1'b0;
            if (mode_wr)
            begin
              o_saved <= 1'b0;
              if (i_setting_value == `ACS_MODE_TUNE_SAVE)
                o_mode <= `ACS_SEL_TUNE;
              else if (i_setting_value == `ACS_MODE_ENC_SETUP)
                o_mode <= `ACS_SEL_ENC;
              else if (i_setting_value == `ACS_MODE_MT_LIMIT)
                o_mode <= `ACS_SEL_MT;
              else
              begin
                o_mode <= `ACS_SEL_NONE;
                o_warning <= 1'b1;
              end
              o_command_ready_flag <= 1'b1;
              o_rsp_valid <= 1'b1;
            end
            else if (is_save)
            begin
              if (o_mode == `ACS_SEL_ENC || o_mode == `ACS_SEL_MT)
                o_saved <= 1'b1;
              else
                o_warning <= 1'b1;
              o_command_ready_flag <= 1'b1;
              o_rsp_valid <= 1'b1;
            end
            else if (is_exec)
            begin
              // encoder and multi-turn modes need the save step first
              if (o_mode == `ACS_SEL_NONE ||
                  ((o_mode != `ACS_SEL_TUNE) && !o_saved))
              begin
                o_warning <= 1'b1;
                o_command_ready_flag <= 1'b1;
                o_rsp_valid <= 1'b1;
              end
              else
              begin
                exec_mode_reg <= o_mode;
                timer_start <= 1'b1;
                o_command_ready_flag <= 1'b0;
                state_reg <= ST_EXEC;
              end
            end
            else
            begin
              o_warning <= !is_write;
              o_command_ready_flag <= 1'b1;
              o_rsp_valid <= 1'b1;
            end
          end
        end
        ST_EXEC:
        begin
          // frames arriving now are ignored; ready stays low until the delay ends
          o_command_ready_flag <= 1'b0;
          if (timer_done && !timer_busy)
          begin
            case (exec_mode_reg)
              `ACS_SEL_TUNE:
              begin
                o_tune_save_pulse <= 1'b1;
                tune_save_req <= 1'b1;
              end
              `ACS_SEL_ENC: o_enc_setup_pulse <= 1'b1;
              `ACS_SEL_MT: o_mt_limit_pulse <= 1'b1;
              default: o_warning <= 1'b1;
            endcase
            o_mode <= `ACS_SEL_NONE;
            o_saved <= 1'b0;
            o_command_ready_flag <= 1'b1;
            o_rsp_valid <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// >>> acs_regs.vh
// command codes, setting addresses, mode values and timing for the adjusting command sequencer
// included by every design file of the block; no logic here
`ifndef ACS_REGS_VH
`define ACS_REGS_VH

`define ACS_CMD_ADJ 8'h3E
`define ACS_CMD_SUB 8'h00
`define ACS_SUB_WRITE 8'h01
`define ACS_ADDR_MODE 16'h2000
`define ACS_ADDR_STEP 16'h2001
`define ACS_MODE_TUNE_SAVE 16'h1007
`define ACS_MODE_ENC_SETUP 16'h1008
`define ACS_MODE_MT_LIMIT 16'h1013
`define ACS_STEP_EXECUTE 16'h0001
`define ACS_STEP_SAVE 16'h0002

`define ACS_SEL_NONE 2'h0
`define ACS_SEL_TUNE 2'h1
`define ACS_SEL_ENC 2'h2
`define ACS_SEL_MT 2'h3

`define ACS_CLK_HZ 125000000
`define ACS_EXEC_TIME_MS 1000
`define ACS_EXEC_CYCLES (`ACS_CLK_HZ / 1000 * `ACS_EXEC_TIME_MS)

`define ACS_INERTIA_MAX 16'h4E20
`define ACS_INERTIA_RESET 16'h0000
`define ACS_METHOD_ONCE 4'h0
`define ACS_METHOD_CONT 4'h1
`define ACS_METHOD_OFF 4'h2
`define ACS_METHOD_RESET 4'h0

`endif

// >>> acs_exec_timer.v
// delay counter for the execute step; counts enabled cycles up to a limit
// assumes start is a one-cycle pulse and the limit is at least one
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_exec_timer #(
  parameter CYCLES = `ACS_EXEC_CYCLES,
  parameter W = 28
)
(
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_start,
  output reg o_busy,
  output reg o_done
);
  reg [W-1:0] cnt_reg;

  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_reg <= {W{1'b0}};
      o_busy <= 1'b0;
      o_done <= 1'b0;
    end
    else if (i_ce)
    begin
      o_done <= 1'b0;
      if (i_start)
      begin
        cnt_reg <= {W{1'b0}};
        o_busy <= 1'b1;
      end
      else if (o_busy)
      begin
        if (cnt_reg == CYCLES[W-1:0] - 1'b1)
        begin
          o_busy <= 1'b0;
          o_done <= 1'b1;
        end
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end
endmodule

// >>> acs_inertia_store.v
// inertia ratio holding, estimation gated by the method input from the sequencer, with volatile estimate and saved copy
// assumes the saved copy models non-volatile storage surviving only a soft restart
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_inertia_store (
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_restart,
  input wire i_ratio_wr,
  input wire [15:0] i_ratio_wdata,
  input wire [3:0] i_method,
  input wire i_running,
  input wire i_est_valid,
  input wire [15:0] i_est_ratio,
  input wire i_save,
  output reg [15:0] o_ratio_setting,
  output reg [15:0] o_active_ratio,
  output reg o_estimating,
  output reg o_ratio_rejected
);
  reg [15:0] pending_reg;
  reg first_done_reg;
  wire est_allowed;

  // method digit 0 estimates only until the first estimate is taken after power-on
  assign est_allowed = (i_method == `ACS_METHOD_CONT) ||
                       ((i_method == `ACS_METHOD_ONCE) && !first_done_reg);

  always @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pending_reg <= `ACS_INERTIA_RESET;
      o_ratio_setting <= `ACS_INERTIA_RESET;
      o_active_ratio <= `ACS_INERTIA_RESET;
      first_done_reg <= 1'b0;
      o_estimating <= 1'b0;
      o_ratio_rejected <= 1'b0;
    end
    else if (i_ce)
    begin
      o_ratio_rejected <= 1'b0;
      o_estimating <= i_running && est_allowed;
      if (i_restart)
      begin
        // new setting takes effect only at restart; estimate restarts from it
        o_ratio_setting <= pending_reg;
        o_active_ratio <= pending_reg;
        first_done_reg <= 1'b0;
      end
      else
      begin
        if (i_ratio_wr)
        begin
          if (i_ratio_wdata > `ACS_INERTIA_MAX)
            o_ratio_rejected <= 1'b1;
          else
            pending_reg <= i_ratio_wdata;
        end
        if (i_running && est_allowed && i_est_valid)
        begin
          o_active_ratio <= i_est_ratio;
          if (i_method == `ACS_METHOD_ONCE)
            first_done_reg <= 1'b1;
        end
        if (i_save)
          pending_reg <= o_active_ratio;
      end
    end
  end
endmodule

// >>> acs_host.sv
// host controller model: sends adjusting frames and waits for the answer
// assumes the sequencer's clock; fields are scrambled once the strobe drops
`timescale 1ns/1ps
module acs_host (
  input wire i_core_clk,
  input wire i_rdy,
  input wire i_rsp,
  output reg o_vld,
  output reg [7:0] o_b1,
  output reg [7:0] o_b2,
  output reg [7:0] o_sub,
  output reg [15:0] o_adr,
  output reg [15:0] o_val
);
  initial {o_vld, o_b1, o_b2, o_sub, o_adr, o_val} = 57'h0;
  task send(input [15:0] cmd, input [7:0] sub, input [15:0] adr, input [15:0] val);
    begin
      @(posedge i_core_clk);
      o_vld <= 1'b1;
      {o_b1, o_b2} <= cmd;
      {o_sub, o_adr, o_val} <= {sub, adr, val};
      @(posedge i_core_clk);
      o_vld <= 1'b0;
      // stale fields must not look valid to the device
      {o_b1, o_b2, o_sub, o_adr, o_val} <= ~{cmd, sub, adr, val};
    end
  endtask
  task await(input integer n, output reg ok);
    integer k;
    begin
      ok = 1'b0;
      // the answer may already stand in the cycle right after the frame edge
      for (k = 0; k < n && !ok; k = k + 1)
      begin
        #1 ok = i_rsp && i_rdy;
        if (!ok)
          @(posedge i_core_clk);
      end
    end
  endtask
endmodule

// >>> acs_sequencer_chk.sv
// timing checker for the adjusting command sequencer
// assumes i_ce high in normal traffic and a short execute delay
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_sequencer_chk #(
  parameter EXEC_CYCLES = 10
)
(
  input wire i_core_clk,
  input wire i_resetn,
  input wire i_ce,
  input wire i_cmd_valid,
  input wire [7:0] i_cmd_byte1,
  input wire [7:0] i_cmd_byte2,
  input wire [7:0] i_sub_command_code,
  input wire [15:0] i_setting_address,
  input wire [15:0] i_setting_value,
  input wire i_ratio_wr,
  input wire [15:0] i_ratio_wdata,
  input wire o_rsp_valid,
  input wire [7:0] o_sub_command_answer,
  input wire [15:0] o_setting_address,
  input wire [15:0] o_setting_value,
  input wire o_command_ready_flag,
  input wire o_warning,
  input wire o_alarm,
  input wire [1:0] o_mode,
  input wire o_saved,
  input wire o_enc_setup_pulse,
  input wire o_ratio_rejected
);
  // answer is registered EXEC_CYCLES + 2 edges after the take, seen one edge later
  localparam int BUSY = EXEC_CYCLES + 1;
  localparam int DONE = EXEC_CYCLES + 3;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  wire rdy = o_command_ready_flag;
  wire take = i_ce && i_cmd_valid && rdy && i_cmd_byte1 == `ACS_CMD_ADJ
    && i_cmd_byte2 == `ACS_CMD_SUB;
  wire step = take && i_sub_command_code == `ACS_SUB_WRITE
    && i_setting_address == `ACS_ADDR_STEP;
  wire sel = take && i_sub_command_code == `ACS_SUB_WRITE
    && i_setting_address == `ACS_ADDR_MODE;
  wire exec = step && i_setting_value == `ACS_STEP_EXECUTE;
  // tune save needs no save step, the other two do
  wire go = exec && (o_mode == `ACS_SEL_TUNE || (o_mode != `ACS_SEL_NONE && o_saved));
  reg [1:0] exp_mode;
  always @*
  begin
    case (i_setting_value)
      `ACS_MODE_TUNE_SAVE: exp_mode = `ACS_SEL_TUNE;
      `ACS_MODE_ENC_SETUP: exp_mode = `ACS_SEL_ENC;
      `ACS_MODE_MT_LIMIT: exp_mode = `ACS_SEL_MT;
      default: exp_mode = `ACS_SEL_NONE;
    endcase
  end
  sequence s_echo;
    o_rsp_valid && rdy && !o_alarm && o_sub_command_answer == $past(i_sub_command_code)
      && o_setting_address == $past(i_setting_address)
      && o_setting_value == $past(i_setting_value);
  endsequence
  sequence s_busy;
    (!rdy && !o_rsp_valid) throughout (1'b1 ##BUSY 1'b1);
  endsequence
  property p_echo; take && !exec |=> s_echo; endproperty
  property p_ignore; i_cmd_valid && rdy && i_cmd_byte1 != `ACS_CMD_ADJ |=> !o_rsp_valid;
  endproperty
  property p_sel; sel |=> o_mode == $past(exp_mode); endproperty
  property p_busy; go |=> s_busy; endproperty
  property p_done;
    go |-> ##DONE o_rsp_valid && rdy && o_setting_value == `ACS_STEP_EXECUTE
      && o_mode == `ACS_SEL_NONE && o_enc_setup_pulse == ($past(o_mode, DONE) == `ACS_SEL_ENC);
  endproperty
  property p_nomode; step && o_mode == `ACS_SEL_NONE && (i_setting_value == `ACS_STEP_SAVE
    || i_setting_value == `ACS_STEP_EXECUTE) |=> o_rsp_valid && o_warning
    && o_mode == `ACS_SEL_NONE; endproperty
  property p_save; step && i_setting_value == `ACS_STEP_SAVE && o_mode >= `ACS_SEL_ENC
    |=> o_saved && !o_warning; endproperty
  property p_rej; i_ce && i_ratio_wr && i_ratio_wdata > `ACS_INERTIA_MAX
    |-> ##[1:2] o_ratio_rejected; endproperty
  a_echo: assert property (p_echo) else $error("echo wrong");
  a_ignore: assert property (p_ignore) else $error("answered foreign frame");
  a_sel: assert property (p_sel) else $error("mode wrong");
  a_busy: assert property (p_busy) else $error("ready during execute");
  a_done: assert property (p_done) else $error("execute end wrong");
  a_nomode: assert property (p_nomode) else $error("no warning");
  a_save: assert property (p_save) else $error("save refused");
  a_rej: assert property (p_rej) else $error("ratio not refused");
endmodule
bind acs_sequencer acs_sequencer_chk #(.EXEC_CYCLES(EXEC_CYCLES)) chk (.*);

// >>> acs_sequencer_bench.sv
// testbench: adjusting procedures through the host model, inertia settings driven directly
// assumes a 10-cycle execute delay in place of one second
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_sequencer_bench;
  localparam EX = 10;
  reg clk = 1'b0;
  reg rstn = 1'b0;
  reg restart = 1'b0, ratio_wr = 1'b0, method_wr = 1'b0, running = 1'b0, est_valid = 1'b0;
  reg [15:0] ratio_wdata = 16'h0000, est_ratio = 16'h0000;
  reg [3:0] method_wdata = 4'h0;
  reg rej_seen = 1'b0;
  reg ce = 1'b1;
  reg ok;
  integer miscompares = 0, check_count = 0, i;
  wire vld, rsp, rdy, warn, tp, ep, mp, rej, saved, est;
  wire [7:0] b1, b2, sub, ans;
  wire [15:0] adr, val, radr, rval, ratio, act;
  wire [1:0] mode;
  wire [3:0] meth;
  wire [47:0] mlist = {`ACS_MODE_TUNE_SAVE, `ACS_MODE_ENC_SETUP, `ACS_MODE_MT_LIMIT};
  initial forever #4 clk = ~clk;
  acs_host host (.i_core_clk(clk), .i_rdy(rdy), .i_rsp(rsp), .o_vld(vld), .o_b1(b1),
    .o_b2(b2), .o_sub(sub), .o_adr(adr), .o_val(val));
  acs_sequencer #(.EXEC_CYCLES(EX), .TIMER_W(8)) uut (.i_core_clk(clk), .i_resetn(rstn),
    .i_ce(ce), .i_restart(restart), .i_cmd_valid(vld), .i_cmd_byte1(b1),
    .i_cmd_byte2(b2), .i_sub_command_code(sub), .i_setting_address(adr),
    .i_setting_value(val), .i_ratio_wr(ratio_wr), .i_ratio_wdata(ratio_wdata),
    .i_method_wr(method_wr), .i_method_wdata(method_wdata), .i_running(running),
    .i_est_valid(est_valid), .i_est_ratio(est_ratio), .o_rsp_valid(rsp),
    .o_sub_command_answer(ans), .o_setting_address(radr), .o_setting_value(rval),
    .o_command_ready_flag(rdy), .o_warning(warn), .o_alarm(), .o_mode(mode),
    .o_saved(saved), .o_tune_save_pulse(tp), .o_enc_setup_pulse(ep), .o_mt_limit_pulse(mp),
    .o_inertia_ratio_setting(ratio), .o_active_inertia(act), .o_estimating(est),
    .o_autotuning_method_setting(meth), .o_ratio_rejected(rej));
  always @(posedge clk) if (rej) rej_seen <= 1'b1;
  task finish_test;
    begin
      $display("checks=%0d mismatches=%0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task step(input [15:0] cmd, input [15:0] a, input [15:0] v, input e);
    begin
      host.send(cmd, `ACS_SUB_WRITE, a, v);
      host.await(4, ok);
      cmp(ok, e);
    end
  endtask
  // k: 0 ratio write, 1 method write, 2 restart, 3 new estimate
  task poke(input [1:0] k, input [15:0] d);
    begin
      @(posedge clk);
      {ratio_wr, method_wr, restart, est_valid} <= 4'h8 >> k;
      {ratio_wdata, method_wdata, est_ratio} <= {d, d[3:0], d};
      @(posedge clk);
      {ratio_wr, method_wr, restart, est_valid} <= 4'h0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  initial
  begin
    #100000;
    miscompares = miscompares + 1;
    finish_test;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk) running <= 1'b1;
    #1;
    cmp(ratio, `ACS_INERTIA_RESET);
    cmp(meth, `ACS_METHOD_RESET);
    poke(3, 16'h0123);
    cmp(act, 16'h0123);
    @(posedge clk) running <= 1'b0;
    @(posedge clk) running <= 1'b1;
    poke(3, 16'h0456);
    cmp(act, 16'h0123);
    step(16'h3E01, `ACS_ADDR_MODE, `ACS_MODE_ENC_SETUP, 1'b0);
    step(16'h3E00, `ACS_ADDR_STEP, `ACS_STEP_EXECUTE, 1'b1);
    cmp(warn, 1'b1);
    step(16'h1200, `ACS_ADDR_MODE, `ACS_MODE_TUNE_SAVE, 1'b0);
    @(posedge clk) ce <= 1'b0;
    step(16'h3E00, `ACS_ADDR_MODE, `ACS_MODE_TUNE_SAVE, 1'b0);
    @(posedge clk) ce <= 1'b1;
    #1 cmp(mode, `ACS_SEL_NONE);
    for (i = 0; i < 3; i = i + 1)
    begin
      step(16'h3E00, `ACS_ADDR_MODE, mlist[47 - 16 * i -: 16], 1'b1);
      cmp(mode, i + 1);
      cmp({ans, radr[7:0]}, {`ACS_SUB_WRITE, 8'h00});
      cmp(warn, 1'b0);
      cmp(radr, `ACS_ADDR_MODE);
      cmp(rval, mlist[47 - 16 * i -: 16]);
      if (i > 0)
      begin
        step(16'h3E00, `ACS_ADDR_STEP, `ACS_STEP_SAVE, 1'b1);
        cmp(saved, 1'b1);
      end
      host.send(16'h3E00, `ACS_SUB_WRITE, `ACS_ADDR_STEP, `ACS_STEP_EXECUTE);
      host.send(16'h3E00, `ACS_SUB_WRITE, `ACS_ADDR_MODE, `ACS_MODE_TUNE_SAVE);
      #1 cmp(rdy, 1'b0);
      host.await(EX + 8, ok);
      cmp(ok, 1'b1);
      cmp({tp, ep, mp}, 3'b100 >> i);
      cmp(rval, `ACS_STEP_EXECUTE);
      cmp(mode, `ACS_SEL_NONE);
    end
    poke(2, 16'h0000);
    cmp(ratio, 16'h0123);
    cmp(act, 16'h0123);
    poke(0, 16'h4E21);
    cmp(rej_seen, 1'b1);
    poke(0, `ACS_INERTIA_MAX);
    poke(1, `ACS_METHOD_CONT);
    cmp(ratio, 16'h0123);
    poke(2, 16'h0000);
    cmp(ratio, `ACS_INERTIA_MAX);
    cmp(meth, `ACS_METHOD_CONT);
    poke(3, 16'h0200);
    poke(3, 16'h0300);
    cmp(act, 16'h0300);
    poke(1, `ACS_METHOD_OFF);
    poke(2, 16'h0000);
    poke(3, 16'h0500);
    cmp(act, `ACS_INERTIA_MAX);
    cmp(est, 1'b0);
    finish_test;
  end
endmodule
